/* File: src/fsfs_defines.vh */
// constants of the flash driver fault supervisor
`ifndef FSFS_DEFINES_VH
`define FSFS_DEFINES_VH

// ****************************************
// register addresses and reset values
// ****************************************
`define FSFS_ADDR_TIMER      8'h02
`define FSFS_ADDR_CTRL       8'h04
`define FSFS_ADDR_FAULT      8'h05
`define FSFS_CTRL_RST        8'h00
`define FSFS_TIMER_RST       8'h0F
`define FSFS_FAULT_RST       8'h00

// ****************************************
// control_settings fields
// ****************************************
`define FSFS_OUTPUT_MODE_LO  0
`define FSFS_OUTPUT_MODE_HI  1
`define FSFS_OUTPUT_ENABLE   2
`define FSFS_STROBE_EN       3
`define FSFS_STROBE_LEVEL    4
`define FSFS_CURRENT_SEL_LO  6
`define FSFS_CURRENT_SEL_HI  7

// ****************************************
// fault_flags fields
// ****************************************
`define FSFS_F_OVP           7
`define FSFS_F_SHORT         6
`define FSFS_F_OTP           5
`define FSFS_F_TIMEOUT       4
`define FSFS_F_INDICATOR     2
`define FSFS_F_INDUCTOR      1
`define FSFS_F_DIODES        0
`define FSFS_BLOCK_MASK      8'hE6

// ****************************************
// output modes
// ****************************************
`define FSFS_MODE_OFF        2'h0
`define FSFS_MODE_IND        2'h1
`define FSFS_MODE_ASSIST     2'h2
`define FSFS_MODE_FLASH      2'h3

// ****************************************
// timing and current limits
// ****************************************
`define FSFS_CLK_KHZ         20000
`define FSFS_TMO_STEP_MS     50
`define FSFS_TMO_STEP_CYC    (`FSFS_TMO_STEP_MS * `FSFS_CLK_KHZ)
`define FSFS_TMO_BASE_STEPS  5'h02
`define FSFS_ISENSE_LSB_MA   25
`define FSFS_ILIM_0_MA       1250
`define FSFS_ILIM_1_MA       1500
`define FSFS_ILIM_2_MA       1750
`define FSFS_ILIM_3_MA       2000
`define FSFS_ILIM_SIMPLE_MA  1750
`define FSFS_I2C_DEV_ADDR    7'h2A

`endif

/* File: src/fsfs_i2c.v */
// serial register port of the fault supervisor
`default_nettype none
`include "fsfs_defines.vh"

module fsfs_i2c #(
	parameter [6:0] DEV_ADDR = `FSFS_I2C_DEV_ADDR
) (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       scl,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_drive_n,
	output reg        wr_stb,
	output reg  [7:0] reg_addr,
	output reg  [7:0] wr_data,
	input  wire [7:0] rd_data,
	output reg        rd_done
);
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_ADDR = 4'h1;
	localparam [3:0] ST_ACKA = 4'h2;
	localparam [3:0] ST_PTR  = 4'h3;
	localparam [3:0] ST_ACKP = 4'h4;
	localparam [3:0] ST_WDAT = 4'h5;
	localparam [3:0] ST_ACKW = 4'h6;
	localparam [3:0] ST_RDAT = 4'h7;
	localparam [3:0] ST_ACKR = 4'h8;

	reg [3:0] st_reg;
	reg [2:0] cnt_reg;
	reg [7:0] sh_reg;
	reg       rw_reg;
	reg       ack_pend_reg;
	reg       scl_prev_reg;
	reg       sda_prev_reg;

	wire       scl_rise = scl & ~scl_prev_reg;
	wire       scl_fall = ~scl & scl_prev_reg;
	wire       start_c  = scl & scl_prev_reg & sda_prev_reg & ~sda_in;
	wire       stop_c   = scl & scl_prev_reg & ~sda_prev_reg & sda_in;
	wire [7:0] byte_in  = {sh_reg[6:0], sda_in};

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg       <= ST_IDLE;
			cnt_reg      <= 3'h0;
			sh_reg       <= 8'h00;
			rw_reg       <= 1'b0;
			ack_pend_reg <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			sda_out      <= 1'b0;
			sda_drive_n  <= 1'b1;
			wr_stb       <= 1'b0;
			reg_addr     <= 8'h00;
			wr_data      <= 8'h00;
			rd_done      <= 1'b0;
		end else begin
			scl_prev_reg <= scl;
			sda_prev_reg <= sda_in;
			wr_stb       <= 1'b0;
			rd_done      <= 1'b0;
			if (start_c) begin
				st_reg       <= ST_ADDR;
				cnt_reg      <= 3'h0;
				ack_pend_reg <= 1'b0;
				sda_drive_n  <= 1'b1;
			end else if (stop_c) begin
				st_reg       <= ST_IDLE;
				ack_pend_reg <= 1'b0;
				sda_drive_n  <= 1'b1;
			end else if (scl_fall) begin
				// acknowledge is driven for the whole ninth clock
				if (ack_pend_reg) begin
					sda_drive_n  <= 1'b0;
					ack_pend_reg <= 1'b0;
				end else if (st_reg == ST_RDAT) begin
					sda_drive_n <= sh_reg[7];
				end else if (st_reg != ST_ACKA && st_reg != ST_ACKP &&
					st_reg != ST_ACKW) begin
					sda_drive_n <= 1'b1;
				end
			end else if (scl_rise) begin
				case (st_reg)
				ST_ADDR, ST_PTR, ST_WDAT: begin
					sh_reg  <= byte_in;
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == 3'h7) begin
						ack_pend_reg <= 1'b1;
						if (st_reg == ST_ADDR) begin
							rw_reg <= sda_in;
							if (byte_in[7:1] == DEV_ADDR) begin
								st_reg <= ST_ACKA;
							end else begin
								st_reg       <= ST_IDLE;
								ack_pend_reg <= 1'b0;
							end
						end else if (st_reg == ST_PTR) begin
							reg_addr <= byte_in;
							st_reg   <= ST_ACKP;
						end else begin
							wr_data <= byte_in;
							wr_stb  <= 1'b1;
							st_reg  <= ST_ACKW;
						end
					end
				end
				ST_ACKA: begin
					cnt_reg <= 3'h0;
					sh_reg  <= rd_data;
					st_reg  <= rw_reg ? ST_RDAT : ST_PTR;
				end
				ST_ACKP, ST_ACKW: begin
					cnt_reg <= 3'h0;
					st_reg  <= ST_WDAT;
				end
				ST_RDAT: begin
					sh_reg  <= {sh_reg[6:0], 1'b0};
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == 3'h7) begin
						st_reg <= ST_ACKR;
					end
				end
				ST_ACKR: begin
					// read counts as completed at the master's ack bit
					rd_done <= 1'b1;
					cnt_reg <= 3'h0;
					sh_reg  <= rd_data;
					st_reg  <= sda_in ? ST_IDLE : ST_RDAT;
				end
				default: begin
					st_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end
endmodule

`default_nettype wire

/* File: src/fsfs_ilim.v */
// cycle-by-cycle peak inductor current limit
`default_nettype none
`include "fsfs_defines.vh"

module fsfs_ilim (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       run,
	input  wire       serial_mode,
	input  wire [1:0] limit_sel,
	input  wire       cycle_start,
	input  wire [7:0] il_sense,
	output reg        nfet_on
);
	function [7:0] ma_to_code;
		input integer ma;
		integer q;
		begin
			q = ma / `FSFS_ISENSE_LSB_MA;
			ma_to_code = q[7:0];
		end
	endfunction

	reg [7:0] limit_code;

	always @* begin
		if (!serial_mode) begin
			limit_code = ma_to_code(`FSFS_ILIM_SIMPLE_MA);
		end else begin
			case (limit_sel)
			2'h0:    limit_code = ma_to_code(`FSFS_ILIM_0_MA);
			2'h1:    limit_code = ma_to_code(`FSFS_ILIM_1_MA);
			2'h2:    limit_code = ma_to_code(`FSFS_ILIM_2_MA);
			default: limit_code = ma_to_code(`FSFS_ILIM_3_MA);
			endcase
		end
	end

	// limit ends only the current charge phase; next cycle starts again
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			nfet_on <= 1'b0;
		end else if (!run) begin
			nfet_on <= 1'b0;
		end else if (cycle_start) begin
			nfet_on <= 1'b1;
		end else if (il_sense >= limit_code) begin
			nfet_on <= 1'b0;
		end
	end
endmodule

`default_nettype wire

/* File: src/fsfs_core.v */
// fault and supply supervisor of the flash LED driver
`default_nettype none
`include "fsfs_defines.vh"

// Contract
// - over-temperature trip sets fault bit 5 at address 0x05.
// - flash lasting the programmed timeout sets timeout bit 4.
// - serial mode timeout covers register flashes and edge strobe flashes.
// - pending timeout flag does not block further LED events.
// - indicator pin outside its window sets fault bit 2.
// - inductance too low sets broken inductor bit 1.
// - current reaching limit ends that cycle's charge phase only.
// - simple mode peak current limit fixed at 1.75A.
// - serial mode limit from four levels by two control bits.
// - simple mode waits for both enables low after lock-out.
// - serial mode lock-out clears the output enable bit.
// - lock-out leaves every other register bit unchanged.
// - power-on reset starts off with startup register values.
// - supply under 1.8V clears all registers like reset.
// - protection fault sets flag and forces standby or shutdown.
// - completed read of fault register clears its bits.
// - simple mode resumes after fault only with both enables low.
module fsfs_core #(
	parameter TMO_STEP_CYCLES = `FSFS_TMO_STEP_CYC
) (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       serial_mode,
	input  wire       enable_line_a,
	input  wire       enable_line_b,
	input  wire       strobe_pin,
	input  wire       uvlo_det,
	input  wire       ovp_det,
	input  wire       short_det,
	input  wire       otp_det,
	input  wire       indicator_pin_fault,
	input  wire       inductor_low_det,
	input  wire       two_leds,
	input  wire       cycle_start,
	input  wire [7:0] il_sense,
	input  wire       scl,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_drive_n,
	output reg  [1:0] led_mode,
	output reg        flash_on,
	output wire       nfet_on
);
	localparam integer STEP_LAST_I = TMO_STEP_CYCLES - 1;
	localparam [19:0]  STEP_LAST   = STEP_LAST_I[19:0];
	localparam [7:0]   TIMER_RST   = `FSFS_TIMER_RST;

	// ****************************************
	// state
	// ****************************************
	reg  [7:0]  ctrl_reg;
	reg  [7:0]  ctrl_next;
	reg  [7:0]  timer_reg;
	reg  [7:0]  fault_reg;
	reg  [7:0]  fault_next;
	reg         level_reg;
	reg         strobe_prev_reg;
	reg         lock_reg;
	reg         lock_next;
	reg  [19:0] step_cnt_reg;
	reg  [4:0]  steps_reg;
	reg         flash_next;
	reg  [1:0]  mode_next;
	reg  [7:0]  rd_data;

	wire        wr_stb;
	wire [7:0]  reg_addr;
	wire [7:0]  wr_data;
	wire        rd_done;

	// ****************************************
	// register port
	// ****************************************
	fsfs_i2c u_i2c (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.scl         (scl),
		.sda_in      (sda_in),
		.sda_out     (sda_out),
		.sda_drive_n (sda_drive_n),
		.wr_stb      (wr_stb),
		.reg_addr    (reg_addr),
		.wr_data     (wr_data),
		.rd_data     (rd_data),
		.rd_done     (rd_done)
	);

	always @* begin
		case (reg_addr)
		`FSFS_ADDR_TIMER: rd_data = timer_reg;
		`FSFS_ADDR_CTRL:  rd_data = ctrl_reg;
		`FSFS_ADDR_FAULT: rd_data = {fault_reg[7:1], two_leds};
		default:          rd_data = 8'h00;
		endcase
	end

	// ****************************************
	// fault conditions
	// ****************************************
	wire [7:0] cond_vec;
	assign cond_vec[`FSFS_F_OVP]       = ovp_det;
	assign cond_vec[`FSFS_F_SHORT]     = short_det;
	assign cond_vec[`FSFS_F_OTP]       = otp_det;
	assign cond_vec[`FSFS_F_TIMEOUT]   = 1'b0;
	assign cond_vec[3]                 = 1'b0;
	assign cond_vec[`FSFS_F_INDICATOR] = indicator_pin_fault;
	assign cond_vec[`FSFS_F_INDUCTOR]  = inductor_low_det;
	assign cond_vec[`FSFS_F_DIODES]    = 1'b0;

	// timeout bit is left out of the mask so it never blocks
	wire cond_block = |(cond_vec & `FSFS_BLOCK_MASK);
	wire flag_block = |(fault_reg & `FSFS_BLOCK_MASK);
	wire serial_ok  = ~uvlo_det & ~cond_block & ~flag_block;
	wire simple_ok  = ~uvlo_det & ~cond_block & ~lock_reg;

	wire       output_enable_bit        = ctrl_reg[`FSFS_OUTPUT_ENABLE];
	wire [1:0] om         = {ctrl_reg[`FSFS_OUTPUT_MODE_HI],
		ctrl_reg[`FSFS_OUTPUT_MODE_LO]};
	wire       strobe_en  = ctrl_reg[`FSFS_STROBE_EN];
	wire       strobe_lvl = ctrl_reg[`FSFS_STROBE_LEVEL];
	wire       strobe_up  = strobe_pin & ~strobe_prev_reg;
	wire       both_high  = enable_line_a & enable_line_b;
	wire       both_low   = ~enable_line_a & ~enable_line_b;

	// ****************************************
	// flash timeout
	// ****************************************
	wire [4:0] ft_steps = `FSFS_TMO_BASE_STEPS + {1'b0, timer_reg[3:0]};
	// pin mode cannot program the timer, so it keeps the startup duration
	wire [4:0] tmo_steps = serial_mode ? ft_steps :
		(`FSFS_TMO_BASE_STEPS + {1'b0, TIMER_RST[3:0]});
	wire       step_end = (step_cnt_reg == STEP_LAST);
	wire       timeout  = flash_on & step_end &
		(steps_reg == tmo_steps - 5'h01);

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			step_cnt_reg <= 20'h00000;
			steps_reg    <= 5'h00;
		end else if (!flash_on) begin
			step_cnt_reg <= 20'h00000;
			steps_reg    <= 5'h00;
		end else if (step_end) begin
			step_cnt_reg <= 20'h00000;
			steps_reg    <= steps_reg + 5'h01;
		end else begin
			step_cnt_reg <= step_cnt_reg + 20'h00001;
		end
	end

	// ****************************************
	// flash start and end
	// ****************************************
	always @* begin
		flash_next = 1'b0;
		if (serial_mode) begin
			if (flash_on) begin
				// edge strobe ignores the pin once started
				flash_next = ~timeout & output_enable_bit & serial_ok &
					(~level_reg | strobe_pin);
			end else if (output_enable_bit & serial_ok) begin
				flash_next = strobe_en ? strobe_up :
					(om == `FSFS_MODE_FLASH);
			end
		end else begin
			flash_next = both_high & simple_ok & ~timeout;
		end
	end

	// ****************************************
	// simple mode lock
	// ****************************************
	always @* begin
		lock_next = lock_reg;
		if (serial_mode) begin
			lock_next = 1'b0;
		end else if (uvlo_det | cond_block | timeout) begin
			lock_next = 1'b1;
		end else if (both_low) begin
			lock_next = 1'b0;
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always @* begin
		ctrl_next = ctrl_reg;
		if (serial_mode && wr_stb && reg_addr == `FSFS_ADDR_CTRL) begin
			ctrl_next = wr_data;
		end
		// end of flash, lock-out or fault return the part to standby
		if (serial_mode && ((flash_on && !flash_next) || uvlo_det ||
			cond_block || flag_block)) begin
			ctrl_next[`FSFS_OUTPUT_ENABLE] = 1'b0;
		end
	end

	// ****************************************
	// fault flags
	// ****************************************
	always @* begin
		fault_next = fault_reg;
		if (serial_mode && rd_done && reg_addr == `FSFS_ADDR_FAULT) begin
			fault_next = `FSFS_FAULT_RST;
		end
		// a fault present in the clearing cycle stays latched
		fault_next = fault_next | cond_vec;
		if (timeout) begin
			fault_next[`FSFS_F_TIMEOUT] = 1'b1;
		end
	end

	// ****************************************
	// led mode
	// ****************************************
	always @* begin
		mode_next = `FSFS_MODE_OFF;
		if (flash_next) begin
			mode_next = `FSFS_MODE_FLASH;
		end else if (serial_mode) begin
			if (ctrl_next[`FSFS_OUTPUT_ENABLE] && serial_ok &&
				om != `FSFS_MODE_FLASH && !strobe_en) begin
				mode_next = om;
			end
		end else if (simple_ok && !lock_next) begin
			case ({enable_line_a, enable_line_b})
			2'b10:   mode_next = `FSFS_MODE_IND;
			2'b01:   mode_next = `FSFS_MODE_ASSIST;
			default: mode_next = `FSFS_MODE_OFF;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	// nrst is the power-on reset, also taken below the 1.8V threshold
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg        <= `FSFS_CTRL_RST;
			timer_reg       <= `FSFS_TIMER_RST;
			fault_reg       <= `FSFS_FAULT_RST;
			level_reg       <= 1'b0;
			strobe_prev_reg <= 1'b0;
			lock_reg        <= 1'b0;
			led_mode        <= `FSFS_MODE_OFF;
			flash_on        <= 1'b0;
		end else begin
			ctrl_reg        <= ctrl_next;
			fault_reg       <= fault_next;
			strobe_prev_reg <= strobe_pin;
			lock_reg        <= lock_next;
			led_mode        <= mode_next;
			flash_on        <= flash_next;
			if (serial_mode && wr_stb && reg_addr == `FSFS_ADDR_TIMER) begin
				timer_reg <= wr_data;
			end
			if (!flash_on) begin
				level_reg <= strobe_en & strobe_lvl;
			end
		end
	end

	// ****************************************
	// inductor current limit
	// ****************************************
	fsfs_ilim u_ilim (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.run         (flash_on | (led_mode == `FSFS_MODE_ASSIST)),
		.serial_mode (serial_mode),
		.limit_sel   ({ctrl_reg[`FSFS_CURRENT_SEL_HI],
			ctrl_reg[`FSFS_CURRENT_SEL_LO]}),
		.cycle_start (cycle_start),
		.il_sense    (il_sense),
		.nfet_on     (nfet_on)
	);
endmodule

`default_nettype wire

/* File: test/fsfs_host.sv */
// i2c master model standing in for the host processor
`default_nettype none
`include "fsfs_defines.vh"
module fsfs_host (
	input  wire logic ref_clk,
	input  wire logic sda_w,
	output var  logic scl,
	output var  logic sda_rel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ack;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// four cycles a phase keeps clear of the three-cycle minimum
	task automatic hp;
		repeat (4) @(negedge ref_clk);
	endtask
	task automatic bit_io(input logic b, output logic s);
		sda_rel = b;
		hp();
		scl = 1'b1;
		hp();
		s = sda_w;
		scl = 1'b0;
	endtask
	task automatic start;
		sda_rel = 1'b1;
		hp();
		scl = 1'b1;
		hp();
		sda_rel = 1'b0;
		hp();
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_rel = 1'b0;
		hp();
		scl = 1'b1;
		hp();
		sda_rel = 1'b1;
		hp();
	endtask
	task automatic tx(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, ack);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		tx({`FSFS_I2C_DEV_ADDR, 1'b0});
		tx(a);
		tx(d);
		stop();
	endtask
	// the full read with final nack is what clears fault flags
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic s;
		start();
		tx({`FSFS_I2C_DEV_ADDR, 1'b0});
		tx(a);
		start();
		tx({`FSFS_I2C_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(1'b1, s);
		stop();
	endtask
endmodule
`default_nettype wire

/* File: test/fsfs_core_assertions.sv */
// port assertions of the fault supervisor
`default_nettype none
module fsfs_checker #(
	parameter TMO_STEP_CYCLES = 20
) (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       serial_mode,
	input wire logic       enable_line_a,
	input wire logic       enable_line_b,
	input wire logic       uvlo_det,
	input wire logic       ovp_det,
	input wire logic       short_det,
	input wire logic       otp_det,
	input wire logic       indicator_pin_fault,
	input wire logic       inductor_low_det,
	input wire logic       cycle_start,
	input wire logic [7:0] il_sense,
	input wire logic [1:0] led_mode,
	input wire logic       flash_on,
	input wire logic       nfet_on
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic        flt;
	logic        lock_reg;
	logic [15:0] run_reg;
	assign flt = ovp_det | short_det | otp_det | indicator_pin_fault
		| inductor_low_det;
	// lock tracks only pin-mode blocking; timeout locks are not modelled
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			lock_reg <= 1'b0;
			run_reg <= 16'h0000;
		end else begin
			if (!serial_mode && (flt || uvlo_det))
				lock_reg <= 1'b1;
			else if (serial_mode || (!enable_line_a && !enable_line_b))
				lock_reg <= 1'b0;
			run_reg <= flash_on ? run_reg + 16'h0001 : 16'h0000;
		end
	end
	a_fault_off: assert property (
		flt |-> ##[1:2] (led_mode == 2'h0 && !flash_on))
		else $error("led active during fault");
	a_uvlo_off: assert property (
		uvlo_det |-> ##[1:2] (led_mode == 2'h0))
		else $error("led active during lock-out");
	a_simple_lock: assert property (
		lock_reg && $past(lock_reg) |-> led_mode == 2'h0)
		else $error("pin mode resumed too early");
	a_simple_limit: assert property (
		nfet_on && !serial_mode && !cycle_start && il_sense >= 8'h46
		|=> !nfet_on)
		else $error("pin mode limit not applied");
	a_top_limit: assert property (
		nfet_on && !cycle_start && il_sense >= 8'h50 |=> !nfet_on)
		else $error("charge beyond highest limit");
	a_charge_start: assert property (
		cycle_start && led_mode[1] && il_sense < 8'h32 && !flt
		&& !uvlo_det |=> nfet_on)
		else $error("charge phase not started");
	a_flash_bound: assert property (
		run_reg <= 17 * TMO_STEP_CYCLES)
		else $error("flash longer than longest timeout");
	a_flash_mode: assert property (
		flash_on |-> led_mode == 2'h3)
		else $error("flash without flash mode");
endmodule
bind fsfs_core fsfs_checker #(.TMO_STEP_CYCLES(TMO_STEP_CYCLES))
	fsfs_checker_i (.ref_clk, .nrst, .serial_mode, .enable_line_a,
	.enable_line_b, .uvlo_det, .ovp_det, .short_det, .otp_det,
	.indicator_pin_fault, .inductor_low_det, .cycle_start, .il_sense,
	.led_mode, .flash_on, .nfet_on);
`default_nettype wire

/* File: test/flash_driver_fault_supervisor_tb.sv */
// self-checking bench of the flash driver fault supervisor
`default_nettype none
`include "fsfs_defines.vh"
module flash_driver_fault_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int STEP = 20;
	typedef struct packed {logic sm; logic [1:0] sel; logic [7:0] lim;}
		fsfs_row_t;
	logic       ref_clk, nrst, serial_mode, enable_line_a, enable_line_b;
	logic       strobe_pin, uvlo_det, ovp_det, short_det, otp_det;
	logic       indicator_pin_fault, inductor_low_det, two_leds;
	logic       cycle_start, scl, sda_rel, sda_w, sda_out, sda_drive_n;
	logic       flash_on, nfet_on;
	logic [1:0] led_mode;
	logic [4:0] flt;
	logic [7:0] il_sense, rv;
	int         fails, num_checks, n;
	fsfs_row_t  rows [5] = '{'{1'b1, 2'h0, 8'h32}, '{1'b1, 2'h1, 8'h3C},
		'{1'b1, 2'h2, 8'h46}, '{1'b1, 2'h3, 8'h50}, '{1'b0, 2'h0, 8'h46}};
	logic [2:0] pos [5] = '{3'h7, 3'h6, 3'h5, 3'h2, 3'h1};
	assign sda_w = sda_rel & sda_drive_n;
	assign {ovp_det, short_det, otp_det, indicator_pin_fault,
		inductor_low_det} = flt;
	fsfs_core #(.TMO_STEP_CYCLES(STEP)) fsfs_core_i (.ref_clk, .nrst,
		.serial_mode, .enable_line_a, .enable_line_b, .strobe_pin,
		.uvlo_det, .ovp_det, .short_det, .otp_det, .indicator_pin_fault,
		.inductor_low_det, .two_leds, .cycle_start, .il_sense, .scl,
		.sda_in(sda_w), .sda_out, .sda_drive_n, .led_mode, .flash_on,
		.nfet_on);
	fsfs_host fsfs_host_i (.ref_clk, .sda_w, .scl, .sda_rel);
	task automatic chk(input string nm, input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, exp);
		fsfs_host_i.rd(a, rv);
		chk(nm, rv, exp);
	endtask
	task automatic flen(output int k);
		k = 0;
		for (int t = 0; t < 400 && flash_on !== 1'b1; t++)
			cyc(1);
		while (flash_on === 1'b1 && k < 1000) begin
			k++;
			cyc(1);
		end
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// about 13k cycles of traffic expected; 40k cycles, about three times that, means a hang
	initial begin
		#2_000_000;
		fails++;
		final_report();
	end
	initial begin
		{nrst, serial_mode, enable_line_a, enable_line_b} = 4'h4;
		{strobe_pin, uvlo_det, two_leds, cycle_start} = 4'h0;
		flt = 5'h00;
		il_sense = 8'h00;
		cyc(4);
		nrst = 1'b1;
		cyc(2);
		foreach (rows[i]) begin
			serial_mode = rows[i].sm;
			enable_line_b = !rows[i].sm;
			if (rows[i].sm)
				fsfs_host_i.wr(`FSFS_ADDR_CTRL, {rows[i].sel, 6'h06});
			il_sense = 8'h00;
			cyc(3);
			cycle_start = 1'b1;
			cyc(1);
			cycle_start = 1'b0;
			cyc(1);
			chk("charge start", nfet_on, 1'b1);
			il_sense = rows[i].lim - 8'h01;
			cyc(2);
			chk("below limit", nfet_on, 1'b1);
			il_sense = rows[i].lim;
			cyc(2);
			chk("at limit", nfet_on, 1'b0);
		end
		{serial_mode, enable_line_b} = 2'h2;
		$display("current limit rows done");
		fsfs_host_i.wr(`FSFS_ADDR_TIMER, 8'h05);
		nrst = 1'b0;
		cyc(2);
		chk("mode in reset", led_mode, 2'h0);
		chk("sda out", sda_out, 8'h00);
		nrst = 1'b1;
		cyc(2);
		rdc("ctrl", `FSFS_ADDR_CTRL, 8'h00);
		rdc("timer", `FSFS_ADDR_TIMER, 8'h0F);
		rdc("fault", `FSFS_ADDR_FAULT, 8'h00);
		rdc("unmapped", 8'h07, 8'h00);
		$display("reset test done");
		for (int k = 0; k < 5; k++) begin
			fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'h06);
			flt = 5'h10 >> k;
			cyc(3);
			chk("fault mode", led_mode, 2'h0);
			flt = 5'h00;
			rdc("fault bit", `FSFS_ADDR_FAULT, 8'h01 << pos[k]);
			rdc("fault ctrl", `FSFS_ADDR_CTRL, 8'h02);
			rdc("fault clr", `FSFS_ADDR_FAULT, 8'h00);
			fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'h06);
			cyc(2);
			chk("resume", led_mode, 2'h2);
		end
		$display("fault test done");
		fsfs_host_i.wr(`FSFS_ADDR_TIMER, 8'h00);
		for (int r = 0; r < 2; r++) begin
			fork
				fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'h07);
				flen(n);
			join
			chk("reg flash", 8'(n), 8'(2 * STEP));
		end
		rdc("oen off", `FSFS_ADDR_CTRL, 8'h03);
		rdc("timeout", `FSFS_ADDR_FAULT, 8'h10);
		fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'h0F);
		strobe_pin = 1'b1;
		cyc(2);
		strobe_pin = 1'b0;
		flen(n);
		chk("edge flash", 8'(n), 8'(2 * STEP) - 8'h01);
		rdc("edge timeout", `FSFS_ADDR_FAULT, 8'h10);
		fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'h1F);
		strobe_pin = 1'b1;
		cyc(6);
		chk("level flash", flash_on, 1'b1);
		strobe_pin = 1'b0;
		cyc(2);
		chk("level end", flash_on, 1'b0);
		rdc("level no tmo", `FSFS_ADDR_FAULT, 8'h00);
		$display("timeout test done");
		fsfs_host_i.wr(`FSFS_ADDR_CTRL, 8'hC6);
		uvlo_det = 1'b1;
		cyc(3);
		chk("uvlo mode", led_mode, 2'h0);
		uvlo_det = 1'b0;
		rdc("uvlo ctrl", `FSFS_ADDR_CTRL, 8'hC2);
		rdc("uvlo timer", `FSFS_ADDR_TIMER, 8'h00);
		serial_mode = 1'b0;
		for (int j = 0; j < 2; j++) begin
			{enable_line_a, enable_line_b} = 2'h3;
			cyc(3);
			chk("pin flash", led_mode, 2'h3);
			{uvlo_det, flt} = j ? 6'h04 : 6'h20;
			cyc(3);
			{uvlo_det, flt} = 6'h00;
			enable_line_b = 1'b0;
			cyc(3);
			chk("still locked", led_mode, 2'h0);
			enable_line_a = 1'b0;
			cyc(2);
			enable_line_a = 1'b1;
			cyc(3);
			chk("pin resume", led_mode, 2'h1);
			enable_line_a = 1'b0;
			cyc(2);
		end
		$display("lock-out test done");
		final_report();
	end
endmodule
`default_nettype wire
